// ==== frc_cfg.svh ====
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH
// Notes on behaviour
// - Focal point terminates ring into linear bus.
// - Electrical frames retimed, sent on port one.
// - Port two frames detected, sent electrically.
// - Downstream node repeats port two onward.
// - Responses travel back the same way.
// - Focal point drives both ports on failure.
// - Chain failure isolates nodes beyond fault.
// - Healthy links: ports active, faults off.
// - Show electrical receive and rate lock.
// - Show fibre frame reception.
// - Data may drop during reconfiguration.
// - Point-to-point link comes up unconfigured.
// - Idle period restarts detection, drops lock.
// - Rate found from start delimiters.
// - Lost delimiter count restarts detection.
`define FRC_CLK_HZ 25000000
`define FRC_IDLE_S 5
`define FRC_IDLE_CYC (`FRC_IDLE_S * `FRC_CLK_HZ)
`define FRC_LOST_SD_MAX 31
`define FRC_LOCK_SD 2
`define FRC_STRETCH_CYC 16'h0FFF
`define FRC_SD1 8'h10
`define FRC_SD2 8'h68
`define FRC_SD3 8'hA2
`define FRC_SD4 8'hDC
`endif

// ==== frc_pkg.sv ====
package frc_pkg;
  typedef enum logic [1:0] {FRC_SEARCH, FRC_LOCKED} frc_rate_t;
  typedef enum logic [1:0] {FRC_SRC_NONE, FRC_SRC_ELEC, FRC_SRC_P1, FRC_SRC_P2} frc_src_t;
endpackage

// ==== frc_repeater.sv ====
`timescale 1ns/100ps
`include "frc_cfg.svh"
module frc_repeater #(
  parameter int unsigned IDLE_CYC = `FRC_IDLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic focal_point_select,
  input wire logic chain_end,
  input wire logic elec_valid,
  input wire logic [7:0] elec_data,
  input wire logic elec_sof,
  output logic elec_ready,
  input wire logic p1_valid,
  input wire logic [7:0] p1_data,
  input wire logic p1_sof,
  input wire logic p2_valid,
  input wire logic [7:0] p2_data,
  input wire logic p2_sof,
  input wire logic p1_light,
  input wire logic p2_light,
  input wire logic remote_fault_in,
  output logic tx_elec_valid,
  output logic [7:0] tx_elec_data,
  output logic tx_p1_valid,
  output logic [7:0] tx_p1_data,
  output logic tx_p2_valid,
  output logic [7:0] tx_p2_data,
  input wire logic tx_ready,
  output logic port_one_active,
  output logic port_two_active,
  output logic local_link_fault_indicator,
  output logic remote_link_fault_indicator,
  output logic electrical_rx_indicator,
  output logic fibre_rx_indicator,
  output logic rate_lock_indicator,
  output logic ring_redundant
);
  import frc_pkg::*;

  function automatic logic is_sd(input logic [7:0] b);
    is_sd = (b == `FRC_SD1) || (b == `FRC_SD2) || (b == `FRC_SD3) || (b == `FRC_SD4);
  endfunction

  logic ring_fail;
  logic in_valid;
  logic [7:0] in_data;
  logic in_sof;
  frc_src_t in_src;
  logic in_ready;
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, rd_q, rd_d;
  logic [7:0] dat_q [2];
  logic [7:0] dat_d [2];
  frc_src_t src_q [2];
  frc_src_t src_d [2];
  frc_rate_t rate_q, rate_d;
  logic [31:0] idle_q, idle_d;
  logic [7:0] lost_q, lost_d;
  logic [1:0] good_q, good_d;
  logic [15:0] erx_q, erx_d, frx_q, frx_d;
  logic head_valid;
  frc_src_t head_src;
  logic [7:0] head_data;

  assign ring_fail = !p1_light || !p2_light || remote_fault_in;

  // dark port words dropped
  // Input arbitration, electrical side has priority
  always_comb begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_sof = 1'b0;
    in_src = FRC_SRC_NONE;
    if (elec_valid) begin
      in_valid = 1'b1;
      in_data = elec_data;
      in_sof = elec_sof;
      in_src = FRC_SRC_ELEC;
    end else if (p2_valid && p2_light) begin
      in_valid = 1'b1;
      in_data = p2_data;
      in_sof = p2_sof;
      in_src = FRC_SRC_P2;
    end else if (p1_valid && p1_light) begin
      in_valid = 1'b1;
      in_data = p1_data;
      in_sof = p1_sof;
      in_src = FRC_SRC_P1;
    end
  end

  // full buffer drops fibre words
  // Fibre words arriving while the buffer is full are lost; no back-pressure on optics
  assign in_ready = (cnt_q != 2'h2);
  assign elec_ready = in_ready;
  assign head_valid = (cnt_q != 2'h0);
  assign head_src = src_q[rd_q];
  assign head_data = dat_q[rd_q];

  // Two-entry buffer next state
  always_comb begin
    cnt_d = cnt_q;
    wr_d = wr_q;
    rd_d = rd_q;
    dat_d = dat_q;
    src_d = src_q;
    if (in_valid && in_ready) begin
      dat_d[wr_q] = in_data;
      src_d[wr_q] = in_src;
      wr_d = ~wr_q;
    end
    if (head_valid && tx_ready) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, in_valid && in_ready} - {1'b0, head_valid && tx_ready};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      dat_q[0] <= 8'h00;
      dat_q[1] <= 8'h00;
      src_q[0] <= FRC_SRC_NONE;
      src_q[1] <= FRC_SRC_NONE;
    end else begin
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      dat_q <= dat_d;
      src_q <= src_d;
    end
  end

  // Forwarding matrix
  always_comb begin
    tx_elec_valid = 1'b0;
    tx_p1_valid = 1'b0;
    tx_p2_valid = 1'b0;
    if (head_valid && tx_ready) begin
      case (head_src)
        FRC_SRC_ELEC: begin
          tx_p1_valid = 1'b1;
          tx_p2_valid = focal_point_select && ring_fail;
        end
        FRC_SRC_P2: begin
          tx_elec_valid = 1'b1;
          // repeat onward; blocks at focal; terminates ring
          tx_p1_valid = !focal_point_select && !chain_end;
        end
        // responses flow back via port two
        FRC_SRC_P1: begin
          tx_elec_valid = 1'b1;
          tx_p2_valid = !focal_point_select || ring_fail;
        end
        default: begin
          tx_elec_valid = 1'b0;
        end
      endcase
    end
  end

  assign tx_elec_data = head_data;
  assign tx_p1_data = head_data;
  assign tx_p2_data = head_data;

  // Rate detection and indicator stretching
  always_comb begin
    rate_d = rate_q;
    idle_d = idle_q;
    lost_d = lost_q;
    good_d = good_q;
    erx_d = (erx_q != 16'h0000) ? erx_q - 16'h0001 : 16'h0000;
    frx_d = (frx_q != 16'h0000) ? frx_q - 16'h0001 : 16'h0000;
    if (in_valid && in_ready) begin
      idle_d = 32'h00000000;
      if (in_src == FRC_SRC_ELEC) begin
        erx_d = `FRC_STRETCH_CYC;
      end else begin
        frx_d = `FRC_STRETCH_CYC;
      end
      if (in_sof) begin
        if (is_sd(in_data)) begin
          lost_d = 8'h00;
          if (good_q != 2'(`FRC_LOCK_SD)) begin
            good_d = good_q + 2'h1;
          end
          if (good_d == 2'(`FRC_LOCK_SD)) begin
            rate_d = FRC_LOCKED;
          end
        end else if (lost_q + 8'h01 >= 8'(`FRC_LOST_SD_MAX)) begin
          rate_d = FRC_SEARCH;
          lost_d = 8'h00;
          good_d = 2'h0;
        end else begin
          lost_d = lost_q + 8'h01;
        end
      end
    end else if (idle_q >= IDLE_CYC - 1) begin
      rate_d = FRC_SEARCH;
      good_d = 2'h0;
      lost_d = 8'h00;
    end else begin
      idle_d = idle_q + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_q <= FRC_SEARCH;
      idle_q <= 32'h00000000;
      lost_q <= 8'h00;
      good_q <= 2'h0;
      erx_q <= 16'h0000;
      frx_q <= 16'h0000;
    end else begin
      rate_q <= rate_d;
      idle_q <= idle_d;
      lost_q <= lost_d;
      good_q <= good_d;
      erx_q <= erx_d;
      frx_q <= frx_d;
    end
  end

  // port active and fault indicators; link up with light alone
  assign port_one_active = p1_light;
  assign port_two_active = p2_light;
  assign local_link_fault_indicator = !p1_light || !p2_light;
  assign remote_link_fault_indicator = remote_fault_in;
  assign electrical_rx_indicator = (erx_q != 16'h0000);
  assign rate_lock_indicator = (rate_q == FRC_LOCKED);
  assign fibre_rx_indicator = (frx_q != 16'h0000);
  assign ring_redundant = focal_point_select && ring_fail;

  a_focal_both: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_p1_valid && head_src == FRC_SRC_ELEC && focal_point_select && ring_fail) |-> tx_p2_valid)
    else $error("focal point did not drive both ports");
  a_no_bridge: assert property (@(posedge clk) disable iff (!rst_n)
    (focal_point_select && head_src == FRC_SRC_P2) |-> !tx_p1_valid)
    else $error("focal point bridged fibre ports");
  a_elec_fwd: assert property (@(posedge clk) disable iff (!rst_n)
    (head_valid && tx_ready && head_src == FRC_SRC_ELEC) |-> tx_p1_valid)
    else $error("electrical word not sent on port one");
  a_p2_deliver: assert property (@(posedge clk) disable iff (!rst_n)
    (head_valid && tx_ready && head_src == FRC_SRC_P2) |-> tx_elec_valid)
    else $error("port two word not delivered");
  a_fault_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (p1_light && p2_light && !remote_fault_in) |-> (!local_link_fault_indicator && !remote_link_fault_indicator))
    else $error("fault shown on healthy link");
  a_idle_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (idle_q >= IDLE_CYC - 1 && !in_valid) |=> !rate_lock_indicator)
    else $error("lock kept after idle");
  a_erx_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (in_valid && in_ready && in_src == FRC_SRC_ELEC) |=> electrical_rx_indicator)
    else $error("electrical receive not shown");
  a_frx_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (in_valid && in_ready && in_src != FRC_SRC_ELEC) |=> fibre_rx_indicator)
    else $error("fibre receive not shown");
endmodule

// ==== frc_sink.sv ====
`timescale 1ns/100ps
module frc_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_elec_valid,
  input wire logic [7:0] tx_elec_data,
  input wire logic tx_p1_valid,
  input wire logic [7:0] tx_p1_data,
  input wire logic tx_p2_valid,
  input wire logic [7:0] tx_p2_data,
  output logic tx_ready,
  output int n_elec,
  output int n_p1,
  output int n_p2,
  output logic [7:0] last_data
);
  // Slow far side on demand, so the buffer has to absorb a stall
  assign tx_ready = !stall;
  // Count each word taken per port; data is the same head on all ports
  initial begin
    n_elec = 0;
    n_p1 = 0;
    n_p2 = 0;
    last_data = 8'h00;
  end
  always @(posedge clk) begin
    if (tx_ready && tx_elec_valid) begin
      n_elec <= n_elec + 1;
      last_data <= tx_elec_data;
    end
    if (tx_ready && tx_p1_valid) begin
      n_p1 <= n_p1 + 1;
      last_data <= tx_p1_data;
    end
    if (tx_ready && tx_p2_valid) begin
      n_p2 <= n_p2 + 1;
      last_data <= tx_p2_data;
    end
  end
endmodule

// ==== frc_repeater_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module frc_repeater_test;
  import frc_pkg::*;
  logic clk, rst_n, focal, chain_end, stall, remote_fault_in, p1_light, p2_light;
  logic elec_valid, elec_sof, p1_valid, p1_sof, p2_valid, p2_sof, elec_ready, tx_ready;
  logic [7:0] elec_data, p1_data, p2_data, tx_elec_data, tx_p1_data, tx_p2_data, last_data;
  logic tx_elec_valid, tx_p1_valid, tx_p2_valid, act1, act2, flt_l, flt_r;
  logic elec_rx, fib_rx, lock, ring_redundant;
  int n_elec, n_p1, n_p2, errors = 0, n_tests = 0;
  frc_repeater #(.IDLE_CYC(100)) dut_u (.clk(clk), .rst_n(rst_n),
    .focal_point_select(focal), .chain_end(chain_end), .elec_valid(elec_valid),
    .elec_data(elec_data), .elec_sof(elec_sof), .elec_ready(elec_ready),
    .p1_valid(p1_valid), .p1_data(p1_data), .p1_sof(p1_sof), .p2_valid(p2_valid),
    .p2_data(p2_data), .p2_sof(p2_sof), .p1_light(p1_light), .p2_light(p2_light),
    .remote_fault_in(remote_fault_in), .tx_elec_valid(tx_elec_valid),
    .tx_elec_data(tx_elec_data), .tx_p1_valid(tx_p1_valid), .tx_p1_data(tx_p1_data),
    .tx_p2_valid(tx_p2_valid), .tx_p2_data(tx_p2_data), .tx_ready(tx_ready),
    .port_one_active(act1), .port_two_active(act2), .local_link_fault_indicator(flt_l),
    .remote_link_fault_indicator(flt_r), .electrical_rx_indicator(elec_rx),
    .fibre_rx_indicator(fib_rx), .rate_lock_indicator(lock),
    .ring_redundant(ring_redundant));
  frc_sink sink_u (.clk(clk), .stall(stall), .tx_elec_valid(tx_elec_valid),
    .tx_elec_data(tx_elec_data), .tx_p1_valid(tx_p1_valid), .tx_p1_data(tx_p1_data),
    .tx_p2_valid(tx_p2_valid), .tx_p2_data(tx_p2_data), .tx_ready(tx_ready),
    .n_elec(n_elec), .n_p1(n_p1), .n_p2(n_p2), .last_data(last_data));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One byte from a source: 0 electrical, 1 port one, 2 port two
  task automatic send(input int src, input logic [7:0] d, input logic s);
    @(negedge clk);
    {elec_valid, p1_valid, p2_valid} = {src == 0, src == 1, src == 2};
    {elec_data, p1_data, p2_data} = {3{d}};
    {elec_sof, p1_sof, p2_sof} = {3{s}};
    // Ready only moves at a rising edge, so its value here holds at the next one
    while (src == 0 && !elec_ready) @(negedge clk);
    @(negedge clk);
    {elec_valid, p1_valid, p2_valid} = 3'h0;
  endtask
  // Send one delimiter byte and judge which ports carried it
  task automatic route(input int src, input logic [7:0] d, input int ee, e1, e2);
    int c0, c1, c2;
    logic [7:0] prev;
    {c0, c1, c2} = {n_elec, n_p1, n_p2};
    prev = last_data;
    send(src, d, 1'b1);
    repeat (4) @(negedge clk);
    `CHK(n_elec - c0, ee)
    `CHK(n_p1 - c1, e1)
    `CHK(n_p2 - c2, e2)
    `CHK(last_data, (ee + e1 + e2 > 0) ? d : prev)
  endtask
  task t_links;
    `CHK({act1, act2, flt_l, flt_r}, 4'hC)
    p2_light = 1'b0;
    @(negedge clk);
    `CHK({act2, flt_l}, 2'h1)
    remote_fault_in = 1'b1;
    @(negedge clk);
    `CHK(flt_r, 1'b1)
    {p2_light, remote_fault_in} = 2'h2;
  endtask
  task t_master;
    route(0, 8'h68, 0, 1, 0);
    `CHK(elec_rx, 1'b1)
    route(0, 8'h10, 0, 1, 0);
    `CHK(lock, 1'b1)
  endtask
  task t_downstream;
    route(2, 8'hA2, 1, 1, 0);
    `CHK(fib_rx, 1'b1)
    chain_end = 1'b1;
    route(2, 8'hDC, 1, 0, 0);
    chain_end = 1'b0;
    route(1, 8'h68, 1, 0, 1);
    p2_light = 1'b0;
    route(2, 8'hA2, 0, 0, 0);
    p2_light = 1'b1;
  endtask
  task t_focal;
    focal = 1'b1;
    route(1, 8'h10, 1, 0, 0);
    route(2, 8'hA2, 1, 0, 0);
    `CHK(ring_redundant, 1'b0)
    p1_light = 1'b0;
    #1 `CHK(ring_redundant, 1'b1)
    route(0, 8'hDC, 0, 1, 1);
    {p1_light, focal} = 2'h2;
  endtask
  task t_lost_sd;
    for (int i = 0; i < 30; i++) send(0, 8'h55, 1'b1);
    repeat (2) @(negedge clk);
    `CHK(lock, 1'b1)
    send(0, 8'h55, 1'b1);
    repeat (2) @(negedge clk);
    `CHK(lock, 1'b0)
  endtask
  task t_idle;
    route(0, 8'h68, 0, 1, 0);
    route(0, 8'h68, 0, 1, 0);
    `CHK(lock, 1'b1)
    repeat (120) @(negedge clk);
    `CHK(lock, 1'b0)
  endtask
  // Receiver stalls: two words held, a fibre word refused, nothing taken is lost
  task t_buffer;
    int c0, c1;
    {c0, c1} = {n_elec, n_p1};
    stall = 1'b1;
    send(0, 8'h10, 1'b1);
    send(0, 8'h68, 1'b1);
    `CHK(elec_ready, 1'b0)
    send(1, 8'hA2, 1'b1);
    stall = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(n_p1 - c1, 2)
    `CHK(n_elec - c0, 0)
    `CHK(last_data, 8'h68)
    `CHK(elec_ready, 1'b1)
  endtask
  initial begin
    {rst_n, focal, chain_end, stall, remote_fault_in} = 5'h00;
    {p1_light, p2_light, elec_valid, elec_sof, p1_valid, p1_sof, p2_valid, p2_sof} = 8'hC0;
    {elec_data, p1_data, p2_data} = 24'h000000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_links;
    t_master;
    t_downstream;
    t_focal;
    t_lost_sd;
    t_idle;
    t_buffer;
    complete_run;
  end
  // Watchdog, well past the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule
